// file: logic/esr_consts.vh
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH
// status word bit positions
`define ESR_ST_POSTED_SPACE      0
`define ESR_ST_NONPOSTED_SPACE   1
`define ESR_ST_WIRE_SPACE        2
`define ESR_ST_OUTBAND_SPACE     3
`define ESR_ST_POSTED_PEND       4
`define ESR_ST_NONPOSTED_PEND    5
`define ESR_ST_WIRE_PEND         6
`define ESR_ST_OUTBAND_PEND      7
`define ESR_ST_STORE_CPL_SPACE   8
`define ESR_ST_STORE_REQ_SPACE   9
`define ESR_ST_STORE_CPL_PEND    12
`define ESR_ST_STORE_REQ_PEND    13
// local bus offset of the status word
`define ESR_LOCAL_STATUS_OFS     8'h00
// configuration offsets
`define ESR_CFG_DEVICE_ID        16'h0004
`define ESR_CFG_GENERAL          16'h0008
`define ESR_CFG_CHANNEL0         16'h0010
`define ESR_CFG_CHANNEL1         16'h0020
`define ESR_CFG_CHANNEL2         16'h0030
`define ESR_CFG_CHANNEL3         16'h0040
// device identification value
`define ESR_DEVICE_ID_RESET      32'h00000001
// general register: writable bits and reset
`define ESR_GENERAL_WMASK        32'h9c70f000
`define ESR_GENERAL_RESET        32'h00000000
// channel 0: writable bits and reset
`define ESR_CHANNEL0_WMASK       32'h00007700
`define ESR_CHANNEL0_RESET       32'h00001100
// channels 1 to 3: writable bits and reset
`define ESR_CHANNELN_WMASK       32'h00000001
`define ESR_CHANNELN_RESET       32'h00000000
`endif

// file: logic/esr_sync.v
module esr_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta;
	always @(posedge clk) begin
		if (sys_rst) begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // esr_sync

// file: logic/esr_regs.v
// Summary of operation
// R1: get status command returns status word
// R2: local read at offset zero returns status
// R3: every response phase carries current status
// R4: decode command only after chip select deasserts
// R5: queued effects seen in next transaction
// R6: status read-only, cleared by link reset
// R7: bit 0 posted queue space
// R8: bit 1 nonposted queue space
// R9: bit 4 posted data pending
// R10: bit 5 nonposted data pending
// R11: bit 6 virtual wire pending
// R12: space bits 2 3 8 9 tied one
// R13: pending bits 7 12 13 tied zero
// R14: reserved status bits read zero
// R15: get and set configuration serviced
// R16: set configuration applied at chip select release
// R17: configuration registers reset by link reset
// R18: identification 0x4, general 0x8
// R19: channel registers at 0x10 to 0x40
// R20: unmapped reads zero, writes ignored
`include "esr_consts.vh"
module esr_regs #(
	parameter [1:0] MODE_OF_OPERATION = 2'b00,
	parameter [2:0] FREQ_SUPPORTED    = 3'b000,
	parameter [7:0] CHANNELS_SUPPORTED = 8'h03,
	parameter [2:0] MAX_PAYLOAD_SUPPORTED = 3'b001
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        link_reset_n,
	input  wire        link_cs_n,
	input  wire        cmd_get_status,
	input  wire        cmd_get_config,
	input  wire        cmd_set_config,
	input  wire [15:0] cmd_cfg_addr,
	input  wire [31:0] cmd_cfg_wdata,
	input  wire        posted_queue_full,
	input  wire        nonposted_queue_full,
	input  wire        wire_queue_pending,
	input  wire        channel0_ready,
	input  wire        local_read,
	input  wire [7:0]  local_address,
	output reg  [15:0] response_status,
	output reg  [31:0] response_cfg_data,
	output reg         response_cfg_valid,
	output reg  [31:0] local_readdata,
	output reg         local_readdata_valid,
	output reg  [31:0] general_config,
	output reg  [31:0] channel0_config,
	output reg  [31:0] channel1_config,
	output reg  [31:0] channel2_config,
	output reg  [31:0] channel3_config
);
	// link pins and command fields synchronised
	localparam SYNC_W = 54;
	wire [SYNC_W-1:0] sync_in;
	wire [SYNC_W-1:0] sync_out;
	assign sync_in = {link_reset_n, link_cs_n, cmd_get_status,
		cmd_get_config, cmd_set_config, wire_queue_pending,
		cmd_cfg_addr, cmd_cfg_wdata};
	esr_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (sync_in),
		.dout    (sync_out)
	);
	wire        rst_n_s    = sync_out[53];
	wire        cs_n_s     = sync_out[52];
	wire        get_st_s   = sync_out[51];
	wire        get_cfg_s  = sync_out[50];
	wire        set_cfg_s  = sync_out[49];
	wire        wire_pnd_s = sync_out[48];
	wire [15:0] addr_s     = sync_out[47:32];
	wire [31:0] wdata_s    = sync_out[31:0];

	reg         cs_n_d;
	reg         pend_set;
	reg         pend_get;
	reg  [15:0] pend_addr;
	reg  [31:0] pend_data;
	reg  [15:0] status_word;
	reg  [15:0] next_status;
	reg  [31:0] cfg_rd;
	reg         addr_hit;

	// link reset also clears all link state
	wire link_rst   = sys_rst | ~rst_n_s; // [R6] [R17]
	wire cs_rise    = cs_n_s & ~cs_n_d;
	wire cs_fall    = ~cs_n_s & cs_n_d;
	wire cs_active  = ~cs_n_s;
	// command decoded only once the frame is over
	wire cfg_answer = cs_rise & pend_get & ~pend_set; // [R4] [R15]
	wire cfg_apply  = cs_rise & pend_set & addr_hit; // [R16] [R20]
	wire wr_general = cfg_apply & (pend_addr == `ESR_CFG_GENERAL);
	wire wr_chan0   = cfg_apply & (pend_addr == `ESR_CFG_CHANNEL0);
	wire wr_chan1   = cfg_apply & (pend_addr == `ESR_CFG_CHANNEL1);
	wire wr_chan2   = cfg_apply & (pend_addr == `ESR_CFG_CHANNEL2);
	wire wr_chan3   = cfg_apply & (pend_addr == `ESR_CFG_CHANNEL3);
	wire local_hit  = (local_address == `ESR_LOCAL_STATUS_OFS);

	// live status from queue state
	always @* begin
		next_status = 16'h0000; // [R14]
		next_status[`ESR_ST_POSTED_SPACE]    = ~posted_queue_full; // [R7]
		next_status[`ESR_ST_NONPOSTED_SPACE] = ~nonposted_queue_full; // [R8]
		next_status[`ESR_ST_WIRE_SPACE]      = 1'b1; // [R12]
		next_status[`ESR_ST_OUTBAND_SPACE]   = 1'b1; // [R12]
		next_status[`ESR_ST_STORE_CPL_SPACE] = 1'b1; // [R12]
		next_status[`ESR_ST_STORE_REQ_SPACE] = 1'b1; // [R12]
		next_status[`ESR_ST_POSTED_PEND]     = posted_queue_full; // [R9]
		next_status[`ESR_ST_NONPOSTED_PEND]  = nonposted_queue_full; // [R10]
		next_status[`ESR_ST_WIRE_PEND]       = wire_pnd_s; // [R11]
		next_status[`ESR_ST_OUTBAND_PEND]    = 1'b0; // [R13]
		next_status[`ESR_ST_STORE_CPL_PEND]  = 1'b0; // [R13]
		next_status[`ESR_ST_STORE_REQ_PEND]  = 1'b0; // [R13]
	end

	// configuration read decode
	always @* begin
		addr_hit = 1'b1;
		case (pend_addr) // [R18] [R19]
		`ESR_CFG_DEVICE_ID: cfg_rd = `ESR_DEVICE_ID_RESET;
		`ESR_CFG_GENERAL: cfg_rd = general_config |
			{6'h00, MODE_OF_OPERATION, 5'h00, FREQ_SUPPORTED,
			8'h00, CHANNELS_SUPPORTED};
		`ESR_CFG_CHANNEL0: cfg_rd = channel0_config |
			{25'h0, MAX_PAYLOAD_SUPPORTED, 2'b00, channel0_ready, 1'b0};
		`ESR_CFG_CHANNEL1: cfg_rd = channel1_config;
		`ESR_CFG_CHANNEL2: cfg_rd = channel2_config;
		`ESR_CFG_CHANNEL3: cfg_rd = channel3_config;
		default: begin
			cfg_rd   = 32'h00000000; // [R20]
			addr_hit = 1'b0;
		end
		endcase
	end

	// frame edge tracker
	always @(posedge clk) begin
		if (link_rst) begin
			cs_n_d <= 1'b1;
		end else begin
			cs_n_d <= cs_n_s;
		end
	end

	// status only refreshed between transactions
	always @(posedge clk) begin
		if (link_rst) begin
			status_word <= 16'h0000; // [R6]
		end else begin
			if (cs_n_s) begin
				status_word <= next_status; // [R5]
			end
		end
	end

	// each transaction starts with current status
	always @(posedge clk) begin
		if (link_rst) begin
			response_status <= 16'h0000; // [R6]
		end else begin
			if (cs_fall) begin
				response_status <= status_word; // [R3] [R1]
			end
		end
	end

	// read command held until frame end
	always @(posedge clk) begin
		if (link_rst) begin
			pend_get <= 1'b0;
		end else if (cs_active) begin
			pend_get <= get_cfg_s | get_st_s; // [R1] [R15]
		end else if (cs_rise) begin
			pend_get <= 1'b0; // [R4]
		end
	end

	// write command held until frame end
	always @(posedge clk) begin
		if (link_rst) begin
			pend_set <= 1'b0;
		end else if (cs_active) begin
			pend_set <= set_cfg_s; // [R15]
		end else if (cs_rise) begin
			pend_set <= 1'b0; // [R4]
		end
	end

	// address captured during frame
	always @(posedge clk) begin
		if (link_rst) begin
			pend_addr <= 16'h0000;
		end else begin
			if (cs_active) begin
				pend_addr <= addr_s;
			end
		end
	end

	// write data captured during frame
	always @(posedge clk) begin
		if (link_rst) begin
			pend_data <= 32'h00000000;
		end else begin
			if (cs_active) begin
				pend_data <= wdata_s; // [R16]
			end
		end
	end

	// configuration read answer
	always @(posedge clk) begin
		if (link_rst) begin
			response_cfg_data <= 32'h00000000;
		end else begin
			if (cfg_answer) begin
				response_cfg_data <= cfg_rd; // [R15]
			end
		end
	end

	// one cycle answer strobe
	always @(posedge clk) begin
		if (link_rst) begin
			response_cfg_valid <= 1'b0;
		end else begin
			response_cfg_valid <= cfg_answer; // [R15]
		end
	end

	// general register
	always @(posedge clk) begin
		if (link_rst) begin
			general_config <= `ESR_GENERAL_RESET; // [R17]
		end else begin
			if (wr_general) begin
				general_config <= pend_data & `ESR_GENERAL_WMASK; // [R16]
			end
		end
	end

	// channel 0 register
	always @(posedge clk) begin
		if (link_rst) begin
			channel0_config <= `ESR_CHANNEL0_RESET; // [R17]
		end else begin
			if (wr_chan0) begin
				channel0_config <= pend_data & `ESR_CHANNEL0_WMASK; // [R19]
			end
		end
	end

	// channel 1 register
	always @(posedge clk) begin
		if (link_rst) begin
			channel1_config <= `ESR_CHANNELN_RESET; // [R17]
		end else begin
			if (wr_chan1) begin
				channel1_config <= pend_data & `ESR_CHANNELN_WMASK; // [R19]
			end
		end
	end

	// channel 2 register
	always @(posedge clk) begin
		if (link_rst) begin
			channel2_config <= `ESR_CHANNELN_RESET; // [R17]
		end else begin
			if (wr_chan2) begin
				channel2_config <= pend_data & `ESR_CHANNELN_WMASK; // [R19]
			end
		end
	end

	// channel 3 register
	always @(posedge clk) begin
		if (link_rst) begin
			channel3_config <= `ESR_CHANNELN_RESET; // [R17]
		end else begin
			if (wr_chan3) begin
				channel3_config <= pend_data & `ESR_CHANNELN_WMASK; // [R19]
			end
		end
	end

	// local status read data
	always @(posedge clk) begin
		if (sys_rst) begin
			local_readdata <= 32'h00000000;
		end else if (local_read && local_hit) begin
			local_readdata <= {16'h0000, status_word}; // [R2]
		end else if (local_read) begin
			local_readdata <= 32'h00000000;
		end
	end

	// local read strobe
	always @(posedge clk) begin
		if (sys_rst) begin
			local_readdata_valid <= 1'b0;
		end else begin
			local_readdata_valid <= local_read; // [R2]
		end
	end
endmodule // esr_regs

// file: verification/esr_regs_monitor.sv
module esr_regs_monitor (
	input wire        clk,
	input wire        sys_rst,
	input wire        link_reset_n,
	input wire        link_cs_n,
	input wire        local_read,
	input wire [7:0]  local_address,
	input wire [31:0] local_readdata,
	input wire        local_readdata_valid,
	input wire [15:0] response_status,
	input wire [31:0] general_config,
	input wire [31:0] channel0_config
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire rd0 = local_read && local_address == 8'h00;
	property p_lv; local_read |=> local_readdata_valid; endproperty
	a_lv: assert property (p_lv) else $error("no read valid");
	property p_lz; local_read && !rd0 |=> local_readdata == 32'h0; endproperty
	a_lz: assert property (p_lz) else $error("odd read nonzero");
	property p_lt; rd0 |=> (local_readdata & 32'hffffff8c) == 32'h30c;
	endproperty
	a_lt: assert property (p_lt) else $error("fixed bits");
	property p_lq; rd0 |=> local_readdata[1:0] == ~local_readdata[5:4];
	endproperty
	a_lq: assert property (p_lq) else $error("queue bits");
	property p_rt; $rose(link_cs_n) |-> (response_status & 16'hff8c) == 16'h30c;
	endproperty
	a_rt: assert property (p_rt) else $error("response bits");
	property p_rs; !link_cs_n [*6] |-> $stable(response_status); endproperty
	a_rs: assert property (p_rs) else $error("status moved");
	property p_ga; !link_cs_n [*6] |-> $stable(general_config); endproperty
	a_ga: assert property (p_ga) else $error("early apply");
	property p_lr; !link_reset_n [*4] |=> channel0_config == 32'h1100;
	endproperty
	a_lr: assert property (p_lr) else $error("link reset");
	c_rd: cover property (rd0);
	c_fr: cover property ($rose(link_cs_n));
	c_lr: cover property (!link_reset_n);
endmodule // esr_regs_monitor
bind esr_regs esr_regs_monitor mon (.clk, .sys_rst, .link_reset_n, .link_cs_n,
	.local_read, .local_address, .local_readdata, .local_readdata_valid,
	.response_status, .general_config, .channel0_config);

// file: verification/esr_host_model.sv
module esr_host_model (
	input  wire         clk,
	output logic        link_reset_n = 1'b1,
	output logic        link_cs_n = 1'b1,
	output logic        cmd_get_status = 1'b0,
	output logic        cmd_get_config = 1'b0,
	output logic        cmd_set_config = 1'b0,
	output logic [15:0] cmd_cfg_addr = 16'h0000,
	output logic [31:0] cmd_cfg_wdata = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// one command per frame, held through the sync delay
	task automatic frame(input logic [2:0] c, input logic [15:0] a,
		input logic [31:0] d);
		@(negedge clk);
		link_cs_n = 1'b0;
		{cmd_set_config, cmd_get_config, cmd_get_status} = c;
		cmd_cfg_addr = a;
		cmd_cfg_wdata = d;
		#320;
		link_cs_n = 1'b1;
		#160;
		{cmd_set_config, cmd_get_config, cmd_get_status} = 3'h0;
		cmd_cfg_addr = ~a;
		cmd_cfg_wdata = ~d;
		#160;
	endtask
	task automatic lreset;
		@(negedge clk);
		link_reset_n = 1'b0;
		#80;
		link_reset_n = 1'b1;
		#80;
	endtask
endmodule // esr_host_model

// file: verification/esr_regs_bench.sv
module esr_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        local_read = 1'b0;
	logic [2:0]  q = 3'h0;
	logic [7:0]  local_address = 8'h00;
	wire         link_reset_n, link_cs_n, cmd_get_status, cmd_get_config;
	wire         cmd_set_config, response_cfg_valid, local_readdata_valid;
	wire  [15:0] cmd_cfg_addr, response_status;
	wire  [31:0] cmd_cfg_wdata, response_cfg_data, local_readdata;
	wire  [31:0] general_config, channel0_config, channel1_config;
	wire  [31:0] channel2_config, channel3_config;
	int          n_fail = 0;
	int          check_count = 0;
	int          n_valid = 0;
	esr_host_model host (.clk, .link_reset_n, .link_cs_n, .cmd_get_status,
		.cmd_get_config, .cmd_set_config, .cmd_cfg_addr, .cmd_cfg_wdata);
	esr_regs dut (.clk, .sys_rst, .link_reset_n, .link_cs_n, .cmd_get_status,
		.cmd_get_config, .cmd_set_config, .cmd_cfg_addr, .cmd_cfg_wdata,
		.posted_queue_full(q[2]), .nonposted_queue_full(q[1]),
		.wire_queue_pending(q[0]), .channel0_ready(1'b1), .local_read,
		.local_address, .response_status, .response_cfg_data,
		.response_cfg_valid, .local_readdata, .local_readdata_valid,
		.general_config, .channel0_config, .channel1_config,
		.channel2_config, .channel3_config);
	initial forever #2 clk = ~clk;
	always @(negedge clk) if (response_cfg_valid) n_valid++;
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic lrd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		local_read = 1'b1;
		local_address = a;
		@(negedge clk);
		local_read = 1'b0;
		chk("local", e, local_readdata);
	endtask
	task automatic getc(input logic [15:0] a, input logic [31:0] e);
		host.frame(3'h2, a, 32'h0);
		chk("config", e, response_cfg_data);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000 n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		lrd(8'h00, 32'h30f);
		q = 3'h7;
		lrd(8'h04, 32'h0);
		lrd(8'h00, 32'h37c);
		fork
			host.frame(3'h1, 16'h0, 32'h0);
			#40 q = 3'h0;
		join
		chk("status", 32'h37c, response_status);
		getc(16'h4, 32'h1);
		chk("status", 32'h30f, response_status);
		$display("status test done");
		host.frame(3'h4, 16'h8, 32'hffffffff);
		chk("general", 32'h9c70f000, general_config);
		getc(16'h8, 32'h9c70f003);
		host.frame(3'h4, 16'h10, 32'h0);
		getc(16'h10, 32'h12);
		for (int i = 2; i < 5; i++)
			host.frame(3'h4, 16'(i * 16), 32'h1);
		chk("channel1", 32'h1, channel1_config);
		chk("channel2", 32'h1, channel2_config);
		chk("channel3", 32'h1, channel3_config);
		host.frame(3'h4, 16'hc, 32'hffffffff);
		getc(16'hc, 32'h0);
		chk("general", 32'h9c70f000, general_config);
		chk("answers", 32'h5, n_valid);
		$display("config test done");
		host.lreset;
		chk("general", 32'h0, general_config);
		chk("channel0", 32'h1100, channel0_config);
		chk("status", 32'h0, response_status);
		$display("reset test done");
		report_and_stop;
	end
endmodule // esr_regs_bench
